// [sdl_top.sv]
`timescale 1ns/100ps
`default_nettype none
module sdl_gen import sdl_pkg::*; #(
    parameter int CW = 16,
    parameter bit HS = 1'b1
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_arst_n,
    input  wire logic           i_tick,
    input  wire logic           i_force_off,
    input  wire sdl_cfg_t       i_cfg,
    input  wire logic [255:0]   i_data,
    output sdl_drv_t            o_drv,
    output logic                o_bound,
    output logic                o_dead
);
    if (CW < 8 || CW > 16) begin : g_chk
        $error("sdl_gen: CW must be 8..16");
    end
    function automatic logic [2:0] bias_of(input sdl_mode_t m);
        return (m == SDL_M_PWM5) ? 3'h5 : (m == SDL_M_PWM4) ? 3'h4 :
               (m == SDL_M_PWM3) ? 3'h3 : 3'h2;
    endfunction : bias_of
    function automatic logic pwm_lvl(input logic [2:0] lvl, input logic [2:0] pw);
        return pw < lvl;
    endfunction : pwm_lvl

    sdl_state_t  state_reg;
    sdl_cfg_t    cfg_reg;
    sdl_cfg_t    cfg_next;
    logic [CW-1:0] cnt_reg, dcnt_reg;
    logic [1:0]  ph_reg;
    logic [2:0]  sf_reg, pw_reg, bias, com_idx;
    logic [3:0]  nsf;
    logic        pol_reg, half, p, frame_last;

    always_comb begin
        cfg_next = i_cfg;
        if (i_force_off || (!HS && (i_cfg.mode == SDL_M_PWM4 || i_cfg.mode == SDL_M_PWM5)))
            cfg_next.mode = SDL_M_OFF;
        if (i_cfg.bp_n < 3'h2 || i_cfg.bp_n > 3'h4)
            cfg_next.bp_n = 3'h2;
    end
    assign nsf        = cfg_reg.type_b ? {cfg_reg.bp_n, 1'b0} : {1'b0, cfg_reg.bp_n};
    assign frame_last = i_tick && cnt_reg == '0 && ph_reg == 2'h3 && sf_reg == 3'(nsf - 4'h1);
    assign o_bound    = (state_reg == SDL_S_IDLE)
                      || (state_reg == SDL_S_RUN && frame_last
                          && cfg_reg.dead_div[CW-1:0] == '0)
                      || (state_reg == SDL_S_DEAD && i_tick && dcnt_reg == '0);
    assign o_dead     = (state_reg == SDL_S_DEAD);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= SDL_S_IDLE;
            cfg_reg   <= '0;
            cnt_reg   <= '0;
            dcnt_reg  <= '0;
            ph_reg    <= 2'h0;
            sf_reg    <= 3'h0;
            pol_reg   <= 1'b0;
        end else if (o_bound) begin
            cfg_reg   <= cfg_next;
            state_reg <= (cfg_next.mode == SDL_M_OFF) ? SDL_S_IDLE : SDL_S_RUN;
            cnt_reg   <= cfg_next.sub_div[CW-1:0];
            ph_reg    <= 2'h0;
            sf_reg    <= 3'h0;
            pol_reg   <= ~pol_reg;
        end else if (state_reg == SDL_S_RUN && frame_last) begin
            state_reg <= SDL_S_DEAD;
            dcnt_reg  <= cfg_reg.dead_div[CW-1:0] - 1'b1;
        end else if (state_reg == SDL_S_DEAD && i_tick) begin
            dcnt_reg  <= dcnt_reg - 1'b1;
        end else if (state_reg == SDL_S_RUN && i_tick) begin
            if (cnt_reg == '0) begin
                cnt_reg <= cfg_reg.sub_div[CW-1:0];
                ph_reg  <= ph_reg + 2'h1;
                if (ph_reg == 2'h3)
                    sf_reg <= sf_reg + 3'h1;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign bias = bias_of(cfg_reg.mode);
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            pw_reg <= 3'h0;
        else if (i_tick)
            pw_reg <= (pw_reg >= bias - 3'h1) ? 3'h0 : pw_reg + 3'h1;
    end

    assign half    = cfg_reg.type_b && sf_reg >= cfg_reg.bp_n;
    assign com_idx = half ? sf_reg - cfg_reg.bp_n : sf_reg;
    assign p       = pol_reg ^ half;

    for (genvar k = 0; k < SDL_NBP; k++) begin : g_bp
        logic act;
        assign act = (com_idx == 3'(k));
        always_comb begin
            if (state_reg == SDL_S_DEAD)
                o_drv.bp[k] = 1'b1;
            else if (state_reg == SDL_S_IDLE)
                o_drv.bp[k] = 1'b0;
            else if (cfg_reg.mode == SDL_M_CORR)
                o_drv.bp[k] = act ? p : p ^ ph_reg[0];
            else
                o_drv.bp[k] = pwm_lvl(act ? (p ? bias : 3'h0)
                                          : (p ? 3'h1 : bias - 3'h1), pw_reg);
        end
    end
    for (genvar j = 0; j < SDL_NPIN; j++) begin : g_px
        logic on;
        assign on = i_data[j*4 +: 4][com_idx[1:0]];
        always_comb begin
            if (state_reg == SDL_S_DEAD)
                o_drv.px[j] = 1'b1;
            else if (state_reg == SDL_S_IDLE)
                o_drv.px[j] = 1'b0;
            else if (cfg_reg.mode == SDL_M_CORR)
                o_drv.px[j] = on ? ~p : p;
            else
                o_drv.px[j] = pwm_lvl(on ? (p ? 3'h0 : bias)
                                         : (p ? bias - 3'h1 : 3'h1), pw_reg);
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    property p_subfr_step;
        state_reg == SDL_S_RUN && i_tick && cnt_reg == '0 && !frame_last
            |=> cnt_reg == cfg_reg.sub_div[CW-1:0];
    endproperty
    a_subfr_step: assert property (p_subfr_step) else $error("sub-frame reload wrong");
    property p_dead_count;
        state_reg == SDL_S_DEAD && i_tick && dcnt_reg != '0 |=> dcnt_reg == $past(dcnt_reg) - 1'b1;
    endproperty
    a_dead_count: assert property (p_dead_count) else $error("dead counter wrong");
    property p_sf_range;
        state_reg != SDL_S_IDLE |-> {1'b0, sf_reg} < nsf && cfg_reg.bp_n inside {3'h2, 3'h3, 3'h4};
    endproperty
    a_sf_range: assert property (p_sf_range) else $error("sub-frame index out of range");
    property p_slow_bias;
        !HS |-> !(cfg_reg.mode inside {SDL_M_PWM4, SDL_M_PWM5});
    endproperty
    a_slow_bias: assert property (p_slow_bias) else $error("slow generator high bias");
    property p_off_low;
        state_reg == SDL_S_IDLE |-> o_drv == '0;
    endproperty
    a_off_low: assert property (p_off_low) else $error("off generator drives");
    property p_force_off;
        i_force_off && o_bound |=> state_reg == SDL_S_IDLE;
    endproperty
    a_force_off: assert property (p_force_off) else $error("fast generator runs in deep sleep");
endmodule : sdl_gen

module sdl_top import sdl_pkg::*; (
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic        i_lpo_clk,
    input  wire logic        i_deep_sleep,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [3:0]       o_backplane,
    output logic [63:0]      o_pixel
);
    logic [31:0] ctrl_reg, div_reg, data_reg [SDL_NPORT];
    logic [255:0] data_flat;
    logic        lpo_s1_reg, lpo_s2_reg, lpo_s3_reg, ds1_reg, ds2_reg;
    logic        wr_pend_reg, act_sel_reg, lpo_tick, take;
    logic [11:0] wr_addr_reg;
    sdl_cfg_t    fcfg, scfg;
    sdl_drv_t    fdrv, sdrv;
    logic        fbound, sbound, fdead, sdead;

    function automatic logic [31:0] rd_word(input logic [11:0] a);
        if (a == SDL_OFF_ID)   return {SDL_ID_CODE, SDL_REV};
        if (a == SDL_OFF_DIV)  return div_reg;
        if (a == SDL_OFF_CTRL) return ctrl_reg;
        if (a[11:5] == SDL_OFF_DATA[11:5]) return data_reg[a[4:2]];
        return 32'h0000_0000;
    endfunction : rd_word

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {lpo_s1_reg, lpo_s2_reg, lpo_s3_reg} <= 3'h0;
            {ds1_reg, ds2_reg} <= 2'h0;
        end else begin
            {lpo_s3_reg, lpo_s2_reg, lpo_s1_reg} <= {lpo_s2_reg, lpo_s1_reg, i_lpo_clk};
            {ds2_reg, ds1_reg} <= {ds1_reg, i_deep_sleep};
        end
    end
    assign lpo_tick = lpo_s2_reg & ~lpo_s3_reg;

    // AHB-Lite slave, zero wait states
    assign take = i_hsel && i_hready && i_htrans[1];
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= take && i_hwrite && i_hsize == 3'h2;
            wr_addr_reg <= {i_haddr[11:2], 2'h0};
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= SDL_CTRL_RST;
            div_reg  <= SDL_DIV_RST;
            for (int i = 0; i < SDL_NPORT; i++)
                data_reg[i] <= SDL_DATA_RST;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == SDL_OFF_DIV)
                div_reg <= i_hwdata;
            if (wr_addr_reg == SDL_OFF_CTRL)
                ctrl_reg <= i_hwdata;
            if (wr_addr_reg[11:5] == SDL_OFF_DATA[11:5])
                data_reg[wr_addr_reg[4:2]] <= i_hwdata;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            if (take && !i_hwrite) begin
                if (wr_pend_reg && wr_addr_reg == {i_haddr[11:2], 2'h0}
                    && wr_addr_reg != SDL_OFF_ID
                    && (wr_addr_reg == SDL_OFF_DIV || wr_addr_reg == SDL_OFF_CTRL
                        || wr_addr_reg[11:5] == SDL_OFF_DATA[11:5]))
                    o_hrdata <= i_hwdata;
                else
                    o_hrdata <= rd_word({i_haddr[11:2], 2'h0});
            end
        end
    end

    for (genvar i = 0; i < SDL_NPORT; i++) begin : g_flat
        assign data_flat[i*32 +: 32] = data_reg[i];
    end
    always_comb begin
        fcfg.type_b   = ctrl_reg[SDL_TYPE_BIT];
        fcfg.bp_n     = ctrl_reg[SDL_BPN_LSB +: 3];
        fcfg.mode     = sdl_mode_t'(ctrl_reg[SDL_FMODE_LSB +: 3]);
        fcfg.sub_div  = div_reg[SDL_SUB_LSB +: 16];
        fcfg.dead_div = div_reg[SDL_DEAD_LSB +: 16];
        scfg          = fcfg;
        scfg.mode     = sdl_mode_t'(ctrl_reg[SDL_SMODE_LSB +: 3]);
    end

    sdl_gen #(.CW(16), .HS(1'b1)) u_fast (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_tick      (1'b1),
        .i_force_off (ds2_reg),
        .i_cfg       (fcfg),
        .i_data      (data_flat),
        .o_drv       (fdrv),
        .o_bound     (fbound),
        .o_dead      (fdead)
    );
    sdl_gen #(.CW(8), .HS(1'b0)) u_slow (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_tick      (lpo_tick),
        .i_force_off (1'b0),
        .i_cfg       (scfg),
        .i_data      (data_flat),
        .o_drv       (sdrv),
        .o_bound     (sbound),
        .o_dead      (sdead)
    );

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n)
            act_sel_reg <= 1'b0;
        else if (act_sel_reg ? sbound : fbound)
            act_sel_reg <= ctrl_reg[SDL_SEL_BIT];
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_backplane <= 4'h0;
            o_pixel     <= 64'h0;
        end else begin
            {o_backplane, o_pixel} <= act_sel_reg ? sdrv : fdrv;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    property p_dead_high;
        (act_sel_reg ? sdead : fdead) |=> o_backplane == 4'hF && o_pixel == '1;
    endproperty
    a_dead_high: assert property (p_dead_high) else $error("dead time not high");
    property p_sel_bound;
        act_sel_reg != $past(act_sel_reg) |-> $past(act_sel_reg ? sbound : fbound);
    endproperty
    a_sel_bound: assert property (p_sel_bound) else $error("selection changed mid-frame");
    property p_mux;
        act_sel_reg ##1 act_sel_reg |-> {o_backplane, o_pixel} == $past(sdrv);
    endproperty
    a_mux: assert property (p_mux) else $error("slow generator not on pins");
    property p_id;
        take && !i_hwrite && i_haddr[11:0] == SDL_OFF_ID
            |=> o_hrdata == {SDL_ID_CODE, SDL_REV};
    endproperty
    a_id: assert property (p_id) else $error("identity read wrong");
endmodule : sdl_top
`default_nettype wire

// [sdl_pkg.sv]
package sdl_pkg;
    localparam logic [11:0] SDL_OFF_ID   = 12'h000;
    localparam logic [11:0] SDL_OFF_DIV  = 12'h004;
    localparam logic [11:0] SDL_OFF_CTRL = 12'h008;
    localparam logic [11:0] SDL_OFF_DATA = 12'h100;
    localparam int SDL_NPORT = 8;
    localparam int SDL_NPIN  = 64;
    localparam int SDL_NBP   = 4;
    // generator_config_register fields
    localparam int SDL_SEL_BIT  = 0;
    localparam int SDL_TYPE_BIT = 1;
    localparam int SDL_FMODE_LSB = 4;
    localparam int SDL_SMODE_LSB = 8;
    localparam int SDL_BPN_LSB  = 12;
    // timing_divide_register fields
    localparam int SDL_SUB_LSB  = 0;
    localparam int SDL_DEAD_LSB = 16;
    localparam logic [31:0] SDL_CTRL_RST = 32'h0000_2000;
    localparam logic [31:0] SDL_DIV_RST  = 32'h0000_0000;
    localparam logic [31:0] SDL_DATA_RST = 32'h0000_0000;
    // Identity code and revision are arbitrary values
    localparam logic [15:0] SDL_ID_CODE = 16'h5A3C;
    localparam logic [15:0] SDL_REV     = 16'h0001;
    typedef enum logic [2:0] {
        SDL_M_OFF, SDL_M_CORR, SDL_M_PWM2, SDL_M_PWM3, SDL_M_PWM4, SDL_M_PWM5
    } sdl_mode_t;
    typedef enum logic [1:0] {SDL_S_IDLE, SDL_S_RUN, SDL_S_DEAD} sdl_state_t;
    typedef struct packed {
        logic        type_b;
        logic [2:0]  bp_n;
        sdl_mode_t   mode;
        logic [15:0] sub_div;
        logic [15:0] dead_div;
    } sdl_cfg_t;
    typedef struct packed {
        logic [SDL_NBP-1:0]  bp;
        logic [SDL_NPIN-1:0] px;
    } sdl_drv_t;
endpackage : sdl_pkg

// [sdl_panel.sv]
`timescale 1ns/100ps
`default_nettype none
module sdl_panel (
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    input  wire logic [3:0]  i_backplane,
    input  wire logic [63:0] i_pixel,
    output var  int         o_run,
    output var  int         o_period,
    output var  int         o_n_dead
);
    logic high;
    logic high_reg;
    int   cnt_reg;
    int   run_reg;
    assign high = &{i_backplane, i_pixel};
    // Period counted between starts of the all-high interval
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            high_reg <= 1'b0;
            cnt_reg  <= 0;
            run_reg  <= 0;
            o_run    <= 0;
            o_period <= 0;
            o_n_dead <= 0;
        end else begin
            high_reg <= high;
            run_reg  <= high ? run_reg + 1 : 0;
            cnt_reg  <= (high && !high_reg) ? 1 : cnt_reg + 1;
            if (high && !high_reg) begin
                o_period <= cnt_reg;
                o_n_dead <= o_n_dead + 1;
            end
            if (!high && high_reg) begin
                o_run <= run_reg;
            end
        end
    end
endmodule : sdl_panel
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb import sdl_pkg::*;;
    localparam int TY[7]  = '{0, 0, 0, 1, 1, 0, 0};
    localparam int BPN[7] = '{2, 3, 4, 2, 4, 5, 0};
    localparam int MD[7]  = '{1, 2, 3, 4, 5, 2, 1};
    localparam int EXP[7] = '{19, 27, 35, 35, 67, 19, 19};
    logic        clk = 1'b0;
    logic        arst_n;
    logic        lpo;
    logic        deep;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  bp;
    logic [63:0] px;
    int          run;
    int          period;
    int          n_dead;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    sdl_top dut_u (.i_clk_sys(clk), .i_arst_n(arst_n), .i_lpo_clk(lpo),
        .i_deep_sleep(deep), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(1'b1),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_backplane(bp), .o_pixel(px));
    sdl_panel panel_u (.i_clk_sys(clk), .i_arst_n(arst_n), .i_backplane(bp),
        .i_pixel(px), .o_run(run), .o_period(period), .o_n_dead(n_dead));

    always #25 clk = ~clk;
    // Offset keeps oscillator edges away from system clock edges
    always begin
        #15615;
        lpo = ~lpo;
        #10;
    end

    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
        @(posedge clk);
        #1;
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = 1'b1;
        hsize = sz;
        haddr = {20'h0, a};
        @(posedge clk);
        #1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = d;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = 1'b0;
        haddr = {20'h0, a};
        @(posedge clk);
        #1;
        hsel = 1'b0;
        htrans = 2'h0;
        d = hrdata;
    endtask : rd

    task automatic t_regs;
        logic [31:0] d;
        rd(SDL_OFF_ID, d);
        chk(d, {SDL_ID_CODE, SDL_REV});
        chk(32'(hreadyout), 32'h0000_0001);
        chk(32'(hresp), 32'h0000_0000);
        rd(SDL_OFF_CTRL, d);
        chk(d, SDL_CTRL_RST);
        rd(SDL_OFF_DIV, d);
        chk(d, SDL_DIV_RST);
        rd(SDL_OFF_DATA + 12'h01C, d);
        chk(d, SDL_DATA_RST);
        for (int p = 0; p < 8; p++) begin
            wr(SDL_OFF_DATA + 12'(4 * p), 32'h8765_4321 ^ 32'(p), 3'h2);
        end
        for (int p = 0; p < 8; p++) begin
            rd(SDL_OFF_DATA + 12'(4 * p), d);
            chk(d, 32'h8765_4321 ^ 32'(p));
        end
        wr(SDL_OFF_ID, 32'hFFFF_FFFF, 3'h2);
        rd(SDL_OFF_ID, d);
        chk(d, {SDL_ID_CODE, SDL_REV});
        wr(SDL_OFF_DATA, 32'h0000_00FF, 3'h0);
        rd(SDL_OFF_DATA, d);
        chk(d, 32'h8765_4321);
        rd(12'h0C0, d);
        chk(d, 32'h0000_0000);
    endtask : t_regs

    // Fast generator, C=1 and D=3: frame period plus dead run per config
    task automatic t_fast;
        int m;
        wr(SDL_OFF_DIV, 32'h0003_0001, 3'h2);
        for (int i = 0; i < 7; i++) begin
            wr(SDL_OFF_CTRL, 32'((BPN[i] << 12) | (MD[i] << 4) | (TY[i] << 1)), 3'h2);
            repeat (220) @(posedge clk);
            chk(period, EXP[i]);
            chk(run, 3);
        end
        wr(SDL_OFF_CTRL, 32'h0000_2000, 3'h2);
        repeat (100) @(posedge clk);
        m = n_dead;
        repeat (200) @(posedge clk);
        chk(n_dead, m);
    endtask : t_fast

    // Correlation, two backplanes: active backplane differs from unused ones in odd phases only
    task automatic t_map;
        logic [63:0] e;
        logic [31:0] w;
        int          k;
        wr(SDL_OFF_CTRL, 32'h0000_2010, 3'h2);
        repeat (60) @(posedge clk);
        for (int c = 0; c < 40; c++) begin
            @(posedge clk);
            #1;
            if (bp[0] != bp[1]) begin
                k = (bp[0] != bp[2]) ? 0 : 1;
                for (int j = 0; j < 64; j++) begin
                    w = 32'h8765_4321 ^ 32'(j / 8);
                    e[j] = bp[k] ^ w[4 * (j % 8) + k];
                end
                chk(px[31:0], e[31:0]);
                chk(px[63:32], e[63:32]);
            end
        end
    endtask : t_map

    // Slow generator, C=0 and D=2: ten ticks of 625 clocks per frame
    task automatic t_slow;
        int m;
        wr(SDL_OFF_DIV, 32'h0002_0000, 3'h2);
        wr(SDL_OFF_CTRL, 32'h0000_2101, 3'h2);
        repeat (20000) @(posedge clk);
        chk((period + 312) / 625, 10);
        chk((run + 312) / 625, 2);
        #1;
        deep = 1'b1;
        m = n_dead;
        repeat (13000) @(posedge clk);
        chk(32'(n_dead - m > 1), 1);
        chk((period + 312) / 625, 10);
        wr(SDL_OFF_CTRL, 32'h0000_2401, 3'h2);
        repeat (7000) @(posedge clk);
        m = n_dead;
        repeat (13000) @(posedge clk);
        chk(n_dead, m);
        wr(SDL_OFF_CTRL, 32'h0000_2010, 3'h2);
        repeat (100) @(posedge clk);
        m = n_dead;
        repeat (400) @(posedge clk);
        chk(n_dead, m);
        #1;
        deep = 1'b0;
        repeat (400) @(posedge clk);
        chk(period, 10);
        chk(run, 2);
    endtask : t_slow

    initial begin
        arst_n = 1'b0;
        lpo = 1'b0;
        deep = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_fast();
        t_map();
        t_slow();
        final_report();
    end
endmodule : tb
`default_nettype wire
